/* File: hdl/sdc_pkg.sv */
`default_nettype none

package sdc_pkg;

  localparam int WORD_W = 16;
  localparam int NUM_SW = 6;
  localparam int CNT_W  = 5;

  // Control word fields
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_SW_LO     = 1;
  localparam int CTRL_OL_N_BIT  = 13;
  localparam int CTRL_DLY_BIT   = 14;
  localparam int CTRL_RUN_BIT   = 15;
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'hE000;

  // Status word fields
  localparam int STAT_WARN_BIT   = 0;
  localparam int STAT_SW_LO      = 1;
  localparam int STAT_SHORT_BIT  = 13;
  localparam int STAT_STBY_BIT   = 14;
  localparam int STAT_SUPPLY_BIT = 15;
  localparam logic [WORD_W-1:0] STAT_ALL_ONES = 16'hFFFF;

  // Bits in a complete frame
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;

  // Synchroniser lane positions
  localparam int SYN_CS_N    = 0;
  localparam int SYN_SCLK    = 1;
  localparam int SYN_SDI     = 2;
  localparam int SYN_STBY_N  = 3;
  localparam int SYN_SUPPLY  = 4;
  localparam int SYN_WARN    = 5;
  localparam int SYN_THERM   = 6;
  localparam int SYN_SHORT   = 7;
  localparam int SYN_OPEN    = 13;
  localparam int SYN_W       = 19;

  // Shutdown delays in microseconds
  localparam int CLK_PERIOD_NS = 8;
  localparam int SC_LONG_US    = 100000;
  localparam int SC_SHORT_US   = 12500;
  localparam int OV_LONG_US    = 14000;
  localparam int OV_SHORT_US   = 3500;
  localparam int NS_PER_US     = 1000;
  localparam int TMR_W         = 24;

  typedef enum logic {
    SDC_IDLE   = 1'b0,
    SDC_ACTIVE = 1'b1
  } sdc_xfer_t;

endpackage

`default_nettype wire

/* File: hdl/sdc_tmr_if.sv */
`default_nettype none

interface sdc_tmr_if #(
  parameter int CW = 24
);
  logic          run;
  logic [CW-1:0] limit;
  logic          expired;

  modport ctl (output run, output limit, input expired);
  modport tmr (input run, input limit, output expired);
endinterface

`default_nettype wire

/* File: hdl/sdc_fault_timer.sv */
`default_nettype none

module sdc_fault_timer #(
  parameter int CW = 24
) (
  input  wire logic clk,
  input  wire logic reset_n,
  sdc_tmr_if.tmr    t
);

  logic [CW-1:0] cnt_q;
  logic          expired_q;

  // Restarts from zero whenever the fault goes away
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (!t.run) begin
      cnt_q <= '0;
    end else if (!expired_q) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      expired_q <= 1'b0;
    end else if (!t.run) begin
      expired_q <= 1'b0;
    end else if (cnt_q >= t.limit - CW'(1)) begin
      expired_q <= 1'b1;
    end
  end

  assign t.expired = expired_q;

endmodule // sdc_fault_timer

`default_nettype wire

/* File: hdl/sdc_top.sv */
`default_nettype none

module sdc_top #(
  parameter int SC_LONG_CYC  = sdc_pkg::SC_LONG_US * sdc_pkg::NS_PER_US / sdc_pkg::CLK_PERIOD_NS,
  parameter int SC_SHORT_CYC = sdc_pkg::SC_SHORT_US * sdc_pkg::NS_PER_US / sdc_pkg::CLK_PERIOD_NS,
  parameter int OV_LONG_CYC  = sdc_pkg::OV_LONG_US * sdc_pkg::NS_PER_US / sdc_pkg::CLK_PERIOD_NS,
  parameter int OV_SHORT_CYC = sdc_pkg::OV_SHORT_US * sdc_pkg::NS_PER_US / sdc_pkg::CLK_PERIOD_NS,
  parameter int NUM_SW       = sdc_pkg::NUM_SW
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              serial_data_in,
  output var  logic              sdo,
  output var  logic              sdo_oe,
  input  wire logic              standby_n,
  input  wire logic              supply_fault_in,
  input  wire logic              thermal_warning_in,
  input  wire logic              thermal_off_in,
  input  wire logic [NUM_SW-1:0] short_detect,
  input  wire logic [NUM_SW-1:0] open_load_sense,
  output var  logic [NUM_SW-1:0] drive_on,
  output var  logic [NUM_SW-1:0] ol_current_en
);

  localparam int W  = sdc_pkg::WORD_W;
  localparam int CW = sdc_pkg::TMR_W;
  localparam logic [sdc_pkg::SYN_W-1:0] SYN_IDLE = sdc_pkg::SYN_W'(1) << sdc_pkg::SYN_CS_N;

  logic [sdc_pkg::SYN_W-1:0] syn_meta_q;
  logic [sdc_pkg::SYN_W-1:0] syn_q;
  logic                      cs_n_d1_q;
  logic                      sclk_d1_q;
  logic                      cs_fall;
  logic                      cs_rise;
  logic                      sclk_fall;
  logic                      sclk_rise;
  logic                      sdi_s;
  logic                      standby_n_s;
  logic                      supply_s;
  logic                      thermal_warning;
  logic                      thermal_s;
  logic [NUM_SW-1:0]         short_s;
  logic [NUM_SW-1:0]         open_s;

  sdc_pkg::sdc_xfer_t        xfer_q;
  sdc_pkg::sdc_xfer_t        xfer_d;
  logic [sdc_pkg::CNT_W-1:0] bit_cnt_q;
  logic [W-1:0]              shift_in_q;
  logic [W-1:0]              out_shift_q;
  logic [W-1:0]              control_word_q;
  logic [W-1:0]              diag_status_word;
  logic                      apply_now;
  logic                      status_clear;

  logic                      thermal_off_q;
  logic                      supply_fault_flag_q;
  logic [NUM_SW-1:0]         short_off_q;
  logic [NUM_SW-1:0]         short_exp;
  logic [NUM_SW-1:0]         short_set;
  logic                      supply_exp;
  logic                      supply_off;
  logic                      standby_flag;
  logic                      outputs_allowed;
  logic [NUM_SW-1:0]         sw_ctrl;
  logic [NUM_SW-1:0]         ol_active;
  logic [CW-1:0]             sc_limit;
  logic [CW-1:0]             ov_limit;

  // Every pin crosses two flops; chip select rests high so reset release fakes no frame start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syn_meta_q <= SYN_IDLE;
      syn_q      <= SYN_IDLE;
    end else begin
      syn_meta_q <= {open_load_sense, short_detect, thermal_off_in, thermal_warning_in,
                     supply_fault_in, standby_n, serial_data_in, sclk, cs_n};
      syn_q      <= syn_meta_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_d1_q <= 1'b1;
      sclk_d1_q <= 1'b0;
    end else begin
      cs_n_d1_q <= syn_q[sdc_pkg::SYN_CS_N];
      sclk_d1_q <= syn_q[sdc_pkg::SYN_SCLK];
    end
  end

  assign sdi_s           = syn_q[sdc_pkg::SYN_SDI];
  assign standby_n_s     = syn_q[sdc_pkg::SYN_STBY_N];
  assign supply_s        = syn_q[sdc_pkg::SYN_SUPPLY];
  assign thermal_warning = syn_q[sdc_pkg::SYN_WARN];
  assign thermal_s       = syn_q[sdc_pkg::SYN_THERM];
  assign short_s         = syn_q[sdc_pkg::SYN_SHORT +: NUM_SW];
  assign open_s          = syn_q[sdc_pkg::SYN_OPEN +: NUM_SW];

  assign cs_fall   = cs_n_d1_q && !syn_q[sdc_pkg::SYN_CS_N];
  assign cs_rise   = !cs_n_d1_q && syn_q[sdc_pkg::SYN_CS_N];
  assign sclk_fall = sclk_d1_q && !syn_q[sdc_pkg::SYN_SCLK] && (xfer_q == sdc_pkg::SDC_ACTIVE);
  assign sclk_rise = !sclk_d1_q && syn_q[sdc_pkg::SYN_SCLK] && (xfer_q == sdc_pkg::SDC_ACTIVE);

  // Frame state
  always_comb begin
    xfer_d = xfer_q;
    case (xfer_q)
      sdc_pkg::SDC_IDLE: begin
        if (cs_fall) begin
          xfer_d = sdc_pkg::SDC_ACTIVE;
        end
      end
      sdc_pkg::SDC_ACTIVE: begin
        if (cs_rise) begin
          xfer_d = sdc_pkg::SDC_IDLE;
        end
      end
      default: xfer_d = sdc_pkg::SDC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xfer_q <= sdc_pkg::SDC_IDLE;
    end else begin
      xfer_q <= xfer_d;
    end
  end

  // Receive path: bit count saturates so extra clocks cannot wrap it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q  <= '0;
      shift_in_q <= '0;
    end else if (cs_fall) begin
      bit_cnt_q  <= '0;
      shift_in_q <= '0;
    end else if (sclk_fall) begin
      shift_in_q <= {sdi_s, shift_in_q[W-1:1]};
      if (bit_cnt_q != sdc_pkg::FRAME_BITS) begin
        bit_cnt_q <= bit_cnt_q + sdc_pkg::CNT_ONE;
      end
    end
  end

  // Only a full frame is executed; a short peek at the warning bit is dropped
  assign apply_now    = cs_rise && (bit_cnt_q == sdc_pkg::FRAME_BITS);
  assign status_clear = apply_now && shift_in_q[sdc_pkg::CTRL_CLEAR_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control_word_q <= sdc_pkg::CTRL_RESET;
    end else if (apply_now) begin
      control_word_q <= shift_in_q;
    end
  end

  // Transmit path
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_shift_q <= '0;
      sdo         <= 1'b0;
    end else if (cs_fall) begin
      out_shift_q <= diag_status_word;
      sdo         <= diag_status_word[sdc_pkg::STAT_WARN_BIT];
    end else if (sclk_rise && (bit_cnt_q != '0)) begin
      out_shift_q <= {1'b0, out_shift_q[W-1:1]};
      sdo         <= out_shift_q[1];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_oe <= 1'b0;
    end else if (cs_fall) begin
      sdo_oe <= 1'b1;
    end else if (cs_rise) begin
      sdo_oe <= 1'b0;
    end
  end

  // Fault delays
  assign sc_limit = control_word_q[sdc_pkg::CTRL_DLY_BIT] ? CW'(SC_LONG_CYC) : CW'(SC_SHORT_CYC);
  assign ov_limit = control_word_q[sdc_pkg::CTRL_DLY_BIT] ? CW'(OV_LONG_CYC) : CW'(OV_SHORT_CYC);

  sdc_tmr_if #(.CW(CW)) supply_tif ();
  assign supply_tif.run   = supply_s;
  assign supply_tif.limit = ov_limit;
  assign supply_exp       = supply_tif.expired;

  sdc_fault_timer #(.CW(CW)) u_supply_tmr (
    .clk     (clk),
    .reset_n (reset_n),
    .t       (supply_tif.tmr)
  );

  for (genvar i = 0; i < NUM_SW; i++) begin : g_short
    sdc_tmr_if #(.CW(CW)) tif ();
    assign tif.run   = short_s[i] && drive_on[i];
    assign tif.limit = sc_limit;
    assign short_exp[i] = tif.expired;

    sdc_fault_timer #(.CW(CW)) u_tmr (
      .clk     (clk),
      .reset_n (reset_n),
      .t       (tif.tmr)
    );
  end

  // A short during a temperature warning is cut without waiting
  assign short_set = short_exp | (short_s & drive_on & {NUM_SW{thermal_warning}});

  // Sticky flags: a new event in the clearing cycle wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      short_off_q <= '0;
    end else begin
      short_off_q <= short_set | (short_off_q & ~{NUM_SW{status_clear}});
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      supply_fault_flag_q <= 1'b0;
    end else if (supply_exp && supply_s) begin
      supply_fault_flag_q <= 1'b1;
    end else if (status_clear) begin
      supply_fault_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      thermal_off_q <= 1'b0;
    end else if (thermal_s) begin
      thermal_off_q <= 1'b1;
    end else if (status_clear) begin
      thermal_off_q <= 1'b0;
    end
  end

  // Supply cut follows the live fault so recovery needs no host write
  assign supply_off      = supply_exp && supply_s;
  assign standby_flag    = !control_word_q[sdc_pkg::CTRL_RUN_BIT] || !standby_n_s;
  assign outputs_allowed = !standby_flag && !supply_off && !thermal_off_q;
  assign sw_ctrl         = control_word_q[sdc_pkg::CTRL_SW_LO +: NUM_SW];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_on <= '0;
    end else begin
      drive_on <= sw_ctrl & {NUM_SW{outputs_allowed}} & ~short_off_q;
    end
  end

  // Open-load current only on outputs that are off, never in software standby
  assign ol_active = {NUM_SW{!control_word_q[sdc_pkg::CTRL_OL_N_BIT]
                             && control_word_q[sdc_pkg::CTRL_RUN_BIT]}} & ~sw_ctrl;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ol_current_en <= '0;
    end else begin
      ol_current_en <= ol_active;
    end
  end

  always_comb begin
    diag_status_word = '0;
    if (thermal_off_q) begin
      diag_status_word = sdc_pkg::STAT_ALL_ONES;
    end else begin
      diag_status_word[sdc_pkg::STAT_WARN_BIT] = thermal_warning;
      for (int k = 0; k < NUM_SW; k++) begin
        diag_status_word[sdc_pkg::STAT_SW_LO + k] = ol_active[k] ? open_s[k] : drive_on[k];
      end
      diag_status_word[sdc_pkg::STAT_SHORT_BIT]  = |short_off_q;
      diag_status_word[sdc_pkg::STAT_STBY_BIT]   = standby_flag;
      diag_status_word[sdc_pkg::STAT_SUPPLY_BIT] = supply_fault_flag_q;
    end
  end

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!reset_n);

  AST_CS_RISE_TRISTATE: assert property (
    cs_rise |=> !sdo_oe && (xfer_q == sdc_pkg::SDC_IDLE)
  ) else $error("Data output still enabled after chip select rose");

  AST_CS_FALL_LOADS: assert property (
    cs_fall |=> sdo_oe && (out_shift_q == $past(diag_status_word))
                && (sdo == $past(diag_status_word[sdc_pkg::STAT_WARN_BIT]))
  ) else $error("Status word not captured at chip select fall");

  AST_ABORT_KEEPS_CTRL: assert property (
    (cs_rise && (bit_cnt_q != sdc_pkg::FRAME_BITS)) |=> $stable(control_word_q)
  ) else $error("Partial frame changed the control word");

  AST_FULL_FRAME_APPLIES: assert property (
    apply_now |=> (control_word_q == $past(shift_in_q))
  ) else $error("Full frame not applied at chip select rise");

  AST_SAMPLE_FALL: assert property (
    sclk_fall |=> (shift_in_q[W-1] == $past(sdi_s)) && (shift_in_q[W-2:0] == $past(shift_in_q[W-1:1]))
  ) else $error("Input bit not shifted on falling clock edge");

  AST_SHIFT_RISE: assert property (
    (sclk_rise && (bit_cnt_q != '0) && !cs_fall) |=> (sdo == $past(out_shift_q[1]))
  ) else $error("Output bit did not advance on rising clock edge");

  AST_NO_FIRST_RISE_SHIFT: assert property (
    (sclk_rise && (bit_cnt_q == '0) && !cs_fall) |=> $stable(sdo)
  ) else $error("Bit 0 lost before first falling clock edge");

  AST_STANDBY_OFF: assert property (
    (!control_word_q[sdc_pkg::CTRL_RUN_BIT] || !standby_n_s) |=> (drive_on == '0)
  ) else $error("Output driven during standby");

  AST_SUPPLY_STICKY: assert property (
    (supply_fault_flag_q && !status_clear) |=> supply_fault_flag_q
  ) else $error("Supply fault flag dropped without status clear");

  AST_SUPPLY_SET_CAUSE: assert property (
    $rose(supply_fault_flag_q) |-> $past(supply_exp) && $past(supply_s)
  ) else $error("Supply fault flag set without an expired delay");

  AST_CLEAR_SUPPLY: assert property (
    (status_clear && !supply_s) |=> !supply_fault_flag_q
  ) else $error("Status clear did not clear the supply fault flag");

  AST_THERMAL_ALL_ONES: assert property (
    (cs_fall && thermal_off_q) |=> (out_shift_q == sdc_pkg::STAT_ALL_ONES) && sdo
  ) else $error("Shutdown status not all ones");

endmodule // sdc_top

`default_nettype wire

/* File: sim/sdc_host_model.sv */
`default_nettype none

module sdc_host_model (
  input  wire logic clk,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic serial_data_in,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Link clock and data rest low between frames, as the pull-downs would leave them
  initial begin
    cs_n           = 1'b1;
    sclk           = 1'b0;
    serial_data_in = 1'b0;
  end

  // Period is 10 clk (80 ns): low 3, high 7, so the 3 clk answer delay settles before sampling
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rd, output logic oe_bad);
    rd = 16'h0000;
    oe_bad = sdo_oe;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    // A released line reads as the inverse of the last bit, so a late enable cannot pass
    rd[0] = sdo_oe ? sdo : ~sdo;
    oe_bad = oe_bad | ~sdo_oe;
    for (int i = 0; i < nbits; i++) begin
      // Data moves with the rising edge so it is settled long before the falling edge samples it
      serial_data_in <= w[i];
      sclk           <= 1'b1;
      repeat (7) @(posedge clk);
      if (i > 0) rd[i] = sdo_oe ? sdo : ~sdo;
      sclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    cs_n           <= 1'b1;
    serial_data_in <= 1'b0;
    repeat (8) @(posedge clk);
    oe_bad = oe_bad | sdo_oe;
  endtask
endmodule // sdc_host_model

`default_nettype wire

/* File: sim/serial_driver_control_diag_tb.sv */
`default_nettype none

module serial_driver_control_diag_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int OV_S = 10;
  localparam int OV_L = 40;
  localparam int SC_S = 50;

  logic        clk;
  logic        reset_n;
  logic        cs_n;
  logic        sclk;
  logic        serial_data_in;
  logic        sdo;
  logic        sdo_oe;
  logic        standby_n;
  logic        supply_fault_in;
  logic        thermal_warning_in;
  logic        thermal_off_in;
  logic [5:0]  short_detect;
  logic [5:0]  open_load_sense;
  logic [5:0]  drive_on;
  logic [5:0]  ol_current_en;
  logic [15:0] ctrl_m;
  logic [15:0] rd;
  logic [15:0] w;
  logic [5:0]  shorted_m;
  logic        psf_m;
  logic        scd_m;
  logic        thm_m;
  logic        sup_off_m;
  int          mismatches;
  int          total_checks;

  sdc_top #(
    .SC_LONG_CYC  (200),
    .SC_SHORT_CYC (SC_S),
    .OV_LONG_CYC  (OV_L),
    .OV_SHORT_CYC (OV_S)
  ) u_sdc_top (
    .clk                (clk),
    .reset_n            (reset_n),
    .cs_n               (cs_n),
    .sclk               (sclk),
    .serial_data_in     (serial_data_in),
    .sdo                (sdo),
    .sdo_oe             (sdo_oe),
    .standby_n          (standby_n),
    .supply_fault_in    (supply_fault_in),
    .thermal_warning_in (thermal_warning_in),
    .thermal_off_in     (thermal_off_in),
    .short_detect       (short_detect),
    .open_load_sense    (open_load_sense),
    .drive_on           (drive_on),
    .ol_current_en      (ol_current_en)
  );

  sdc_host_model u_sdc_host_model (
    .clk            (clk),
    .cs_n           (cs_n),
    .sclk           (sclk),
    .serial_data_in (serial_data_in),
    .sdo            (sdo),
    .sdo_oe         (sdo_oe)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [5:0] exp_drive();
    return ctrl_m[6:1] & ~shorted_m & {6{ctrl_m[15] & standby_n & ~sup_off_m & ~thm_m}};
  endfunction

  function automatic logic [15:0] exp_stat();
    logic [15:0] s;
    logic [5:0]  d;
    if (thm_m) return 16'hFFFF;
    d = exp_drive();
    s = 16'h0000;
    s[0] = thermal_warning_in;
    for (int i = 0; i < 6; i++) begin
      s[1+i] = (~ctrl_m[13] & ctrl_m[15] & ~ctrl_m[1+i]) ? open_load_sense[i] : d[i];
    end
    s[13] = scd_m;
    s[14] = ~ctrl_m[15] | ~standby_n;
    s[15] = psf_m;
    return s;
  endfunction

  task automatic cmp_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_vec(input string name, input logic [5:0] exp, input logic [5:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Status is captured at chip select fall, so its expectation predates this frame's write
  task automatic send(input logic [15:0] wd, input int n);
    logic        bad;
    logic [15:0] exp;
    logic [15:0] mask;
    exp  = exp_stat();
    mask = (n == 16) ? 16'hFFFF : 16'h0001;
    u_sdc_host_model.xfer(wd, n, rd, bad);
    cmp_vec("sdo_oe", 6'h00, {5'h00, bad});
    cmp_word("status", exp & mask, rd & mask);
    if (n == 16) begin
      ctrl_m = wd;
      if (wd[0]) begin
        psf_m     = 1'b0;
        scd_m     = 1'b0;
        thm_m     = 1'b0;
        shorted_m = 6'h00;
      end
    end
    repeat (3) @(posedge clk);
    cmp_vec("drive_on", exp_drive(), drive_on);
    if (standby_n & ~thm_m) begin
      cmp_vec("ol_current_en", ~ctrl_m[6:1] & {6{~ctrl_m[13] & ctrl_m[15]}}, ol_current_en);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    logic [15:0] corner [4];
    int          dly;
    corner = '{16'h807E, 16'h007E, 16'hA054, 16'h802A};
    reset_n = 1'b0;
    standby_n = 1'b1;
    supply_fault_in = 1'b0;
    thermal_warning_in = 1'b0;
    thermal_off_in = 1'b0;
    short_detect = 6'h00;
    open_load_sense = 6'h00;
    ctrl_m = 16'hE000;
    shorted_m = 6'h00;
    {psf_m, scd_m, thm_m, sup_off_m} = 4'h0;
    mismatches = 0;
    total_checks = 0;
    void'($urandom(32177));
    repeat (6) @(posedge clk);
    cmp_vec("reset drive_on", 6'h00, drive_on);
    cmp_vec("reset oe", 6'h00, {5'h00, sdo_oe});
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    send(16'hE000, 16);
    // Corner words first, then random words with random standby, warning and open-load senses
    for (int k = 0; k < 28; k++) begin
      w = (k < 4) ? corner[k] : 16'($urandom);
      w[0] = 1'b0;
      @(posedge clk);
      standby_n <= ($urandom % 4) != 0;
      thermal_warning_in <= 1'($urandom);
      open_load_sense <= 6'($urandom);
      repeat (4) @(posedge clk);
      send(w, 16);
    end
    // Short and aborted frames must leave everything as it was
    send(~ctrl_m & 16'hFFFE, 0);
    send(~ctrl_m & 16'hFFFE, 15);
    @(posedge clk);
    standby_n <= 1'b1;
    thermal_warning_in <= 1'b0;
    repeat (4) @(posedge clk);
    send(16'h807E, 16);
    for (int s = 0; s < 2; s++) begin
      dly = s ? OV_L : OV_S;
      send(s ? 16'hC07E : 16'h807E, 16);
      supply_fault_in <= 1'b1;
      repeat (dly - 1) @(posedge clk);
      cmp_vec("drive before expiry", 6'h3F, drive_on);
      repeat (10) @(posedge clk);
      sup_off_m = 1'b1;
      cmp_vec("drive after expiry", exp_drive(), drive_on);
      supply_fault_in <= 1'b0;
      sup_off_m = 1'b0;
      repeat (6) @(posedge clk);
      cmp_vec("drive on return", 6'h3F, drive_on);
      psf_m = 1'b1;
      send(ctrl_m, 16);
      send(ctrl_m | 16'h0001, 16);
    end
    send(16'h807E, 16);
    short_detect <= 6'h04;
    repeat (SC_S - 1) @(posedge clk);
    cmp_vec("drive before short off", 6'h3F, drive_on);
    repeat (12) @(posedge clk);
    cmp_vec("drive after short off", 6'h3B, drive_on);
    short_detect <= 6'h00;
    shorted_m = 6'h04;
    scd_m = 1'b1;
    send(16'h807E, 16);
    send(16'h807F, 16);
    // A short during a temperature warning is cut without waiting for the delay
    thermal_warning_in <= 1'b1;
    short_detect <= 6'h10;
    repeat (8) @(posedge clk);
    cmp_vec("drive warning short", 6'h2F, drive_on);
    short_detect <= 6'h00;
    thermal_warning_in <= 1'b0;
    shorted_m = 6'h10;
    scd_m = 1'b1;
    thermal_off_in <= 1'b1;
    repeat (6) @(posedge clk);
    thm_m = 1'b1;
    cmp_vec("drive thermal", 6'h00, drive_on);
    thermal_off_in <= 1'b0;
    repeat (4) @(posedge clk);
    send(16'h807E, 16);
    send(16'h807F, 16);
    send(16'h807E, 16);
    // Reset in mid-run must bring back the power-on control word
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    ctrl_m = 16'hE000;
    cmp_vec("mid reset drive_on", exp_drive(), drive_on);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    send(16'hE000, 16);
    stop_test();
  end
endmodule // serial_driver_control_diag_tb

`default_nettype wire
